// ===== core/bfs_pkg.sv
package bfs_pkg;
   // clock and serial clock rates
   localparam int CLK_KHZ = 100000;
   localparam int SLOW_SCK_KHZ = 1420;
   localparam int FAST_SCK_KHZ = 30000;
   // half periods of the serial clock, rounded up so the rate never exceeds nominal
   localparam logic [5:0] SLOW_HALF = 6'((CLK_KHZ + 2 * SLOW_SCK_KHZ - 1) / (2 * SLOW_SCK_KHZ));
   localparam logic [5:0] FAST_HALF = 6'((CLK_KHZ + 2 * FAST_SCK_KHZ - 1) / (2 * FAST_SCK_KHZ));
   // least select-high time between two commands
   localparam int CS_HIGH_NS = 200;
   localparam logic [5:0] CS_HIGH_CYC = 6'((CS_HIGH_NS * CLK_KHZ + 999999) / 1000000);
   // poll attempts before a timeout is reported
   localparam logic [23:0] POLL_LIMIT_DEF = 24'hffffff;
   // flash command codes
   localparam logic [7:0] FAST_READ_CMD = 8'h0b;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] SET_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
   localparam logic [7:0] CHIP_ERASE_CMD = 8'hc7;
   localparam logic [7:0] DUMMY_BYTE = 8'h00;
   // flash status byte layout
   localparam int FLASH_BUSY_FLAG_BIT = 0;
   localparam int WRITE_LATCH_FLAG_BIT = 1;
   localparam int PROTECT_LSB = 2;
   localparam int PROTECT_MSB = 6;
   localparam int STATUS_WRITE_LOCK_BIT = 7;
   localparam logic [7:0] STATUS_CLEAR = 8'h00;
   // register byte offsets
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_ADDR = 12'h004;
   localparam logic [11:0] REG_WDATA = 12'h008;
   localparam logic [11:0] REG_RDATA = 12'h00c;
   localparam logic [11:0] REG_STATUS = 12'h010;
   // control fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_LEN_LSB = 2;
   localparam int CTRL_START_BIT = 8;
   localparam int CTRL_CLRERR_BIT = 9;
   // status fields
   localparam int STAT_SEQ_BUSY_BIT = 0;
   localparam int STAT_BOOT_DONE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int STAT_FLASH_LSB = 8;
   // reset values
   localparam logic [1:0] OP_RST = 2'h0;
   localparam logic [1:0] LEN_RST = 2'h0;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [31:0] WDATA_RST = 32'h00000000;
   localparam logic [31:0] RDATA_RST = 32'h00000000;
   localparam logic [7:0] FLASH_STAT_RST = 8'h00;
   // operations, sequencer and bit engine states
   typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE} bfs_op_t;
   typedef enum logic [2:0] {SEQ_IDLE, SEQ_WR_ENABLE, SEQ_POLL_LATCH, SEQ_COMMAND,
      SEQ_POLL_BUSY} bfs_seq_t;
   typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_HIGH, ENG_GAP} bfs_eng_t;
endpackage

// ===== core/bfs_sequencer.sv
// Summary of operation
// - the flash link uses one data line each way in clock mode 0, never dual or quad.
// - status bit 0 is read as the flash busy flag while a write or erase runs.
// - status bit 1 is read as the write latch flag, set once write enable is taken.
// - writing zero to status bits 6 to 2 removes all programming protection.
// - status bit 7, the status write lock, is cleared with the other status bits.
// - status reads and writes carry exactly one status byte, never an expansion byte.
// - protection is assumed on and is removed at every boot, whatever the flash holds.
// - boot sends write enable, polls until the latch is set, then writes status zero.
// - every program or erase is preceded by write enable and a poll until the latch is set.
// - one fixed protocol and clock schedule is used for every flash, with no detection.
// - after reset the serial clock runs near 1.39 MHz, later at 25 MHz, under the 30 MHz fast nominal rate.
// - boot code comes through the first select line; the second line stays idle.
`timescale 1ns/1ps
`default_nettype none
module bfs_sequencer
   import bfs_pkg::*;
#(
   parameter logic [23:0] POLL_LIMIT = POLL_LIMIT_DEF
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic flash_sclk,
   output logic flash_mosi,
   input wire logic flash_miso,
   output logic boot_flash_select_n,
   output logic aux_flash_select_n
);
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic wr_en;
   logic start_req;
   logic clr_err;
   bfs_op_t op_q;
   logic [1:0] len_q;
   logic [23:0] addr_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic [7:0] flash_stat_q;
   logic err_q;
   logic boot_done_q;
   logic latch_ok_q;
   bfs_seq_t seq_q;
   logic wait_q;
   logic [23:0] poll_q;
   logic go;
   logic [71:0] tx_next;
   logic [6:0] bits_next;
   logic poll_fail;
   bfs_eng_t eng_q;
   logic [5:0] cnt_q;
   logic [5:0] half;
   logic [71:0] tx_q;
   logic [6:0] bits_q;
   logic [2:0] bit_idx_q;
   logic [7:0] rx_byte_q;
   logic [31:0] rx_word_q;
   logic done_q;
   logic sclk_q;
   logic mosi_q;
   logic cs0_n_q;
   logic cs1_n_q;
   logic miso_m_q;
   logic miso_s_q;
   logic [7:0] stat_in;

   // outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign flash_sclk = sclk_q;
   assign flash_mosi = mosi_q;
   assign boot_flash_select_n = cs0_n_q;
   assign aux_flash_select_n = cs1_n_q;

   // register read decode
   always_comb
   begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (paddr)
         REG_CTRL: rd_mux = {28'h0000000, len_q, op_q} << CTRL_OP_LSB;
         REG_ADDR: rd_mux = {8'h00, addr_q};
         REG_WDATA: rd_mux = wdata_q;
         REG_RDATA: rd_mux = rdata_q;
         REG_STATUS:
         begin
            rd_mux[STAT_SEQ_BUSY_BIT] = (seq_q != SEQ_IDLE);
            rd_mux[STAT_BOOT_DONE_BIT] = boot_done_q;
            rd_mux[STAT_ERR_BIT] = err_q;
            rd_mux[STAT_FLASH_LSB +: 8] = flash_stat_q;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // apb slave: one wait state, answer registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !rd_hit;
         if (psel && penable && !pready_q && !pwrite)
         begin
            prdata_q <= rd_mux;
         end
      end
   end

   // write takes effect on the edge where pready is seen high
   assign wr_en = psel && penable && pwrite && pready_q;
   assign clr_err = wr_en && (paddr == REG_CTRL) && pwdata[CTRL_CLRERR_BIT];
   assign start_req = wr_en && (paddr == REG_CTRL) && pwdata[CTRL_START_BIT]
      && (seq_q == SEQ_IDLE) && boot_done_q;

   // software registers, frozen while a sequence runs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         op_q <= bfs_op_t'(OP_RST);
         len_q <= LEN_RST;
         addr_q <= ADDR_RST;
         wdata_q <= WDATA_RST;
      end
      else if (wr_en && (seq_q == SEQ_IDLE))
      begin
         if (paddr == REG_CTRL)
         begin
            op_q <= bfs_op_t'(pwdata[CTRL_OP_LSB +: 2]);
            len_q <= pwdata[CTRL_LEN_LSB +: 2];
         end
         if (paddr == REG_ADDR)
         begin
            addr_q <= pwdata[23:0];
         end
         if (paddr == REG_WDATA)
         begin
            wdata_q <= pwdata;
         end
      end
   end

   // frame for the command the sequencer launches next
   always_comb
   begin
      tx_next = 72'h0;
      bits_next = 7'd0;
      case (seq_q)
         SEQ_WR_ENABLE:
         begin
            tx_next = {SET_WRITE_ENABLE_CMD, 64'h0};
            bits_next = 7'd8;
         end
         SEQ_POLL_LATCH, SEQ_POLL_BUSY:
         begin
            tx_next = {STATUS_READ_CMD, 64'h0};
            bits_next = 7'd16;
         end
         SEQ_COMMAND:
         begin
            if (!boot_done_q)
            begin
               tx_next = {STATUS_WRITE_CMD, STATUS_CLEAR, 56'h0};
               bits_next = 7'd16;
            end
            else
            begin
               case (op_q)
                  OP_READ:
                  begin
                     tx_next = {FAST_READ_CMD, addr_q, DUMMY_BYTE, 32'h0};
                     bits_next = 7'd48 + {2'b00, len_q, 3'b000};
                  end
                  OP_PROGRAM:
                  begin
                     tx_next = {PAGE_PROGRAM_CMD, addr_q, wdata_q[7:0], wdata_q[15:8],
                        wdata_q[23:16], wdata_q[31:24], 8'h00};
                     bits_next = 7'd40 + {2'b00, len_q, 3'b000};
                  end
                  OP_SECTOR_ERASE:
                  begin
                     tx_next = {SECTOR_ERASE_CMD, addr_q, 40'h0};
                     bits_next = 7'd32;
                  end
                  default:
                  begin
                     tx_next = {CHIP_ERASE_CMD, 64'h0};
                     bits_next = 7'd8;
                  end
               endcase
            end
         end
         default:
         begin
            tx_next = 72'h0;
            bits_next = 7'd0;
         end
      endcase
   end

   assign go = (seq_q != SEQ_IDLE) && !wait_q;
   assign stat_in = rx_word_q[31:24];
   // poll gave up: wanted state absent at the last permitted attempt
   assign poll_fail = done_q && (poll_q == POLL_LIMIT) && (
      ((seq_q == SEQ_POLL_LATCH) && !stat_in[WRITE_LATCH_FLAG_BIT]) ||
      ((seq_q == SEQ_POLL_BUSY) && stat_in[FLASH_BUSY_FLAG_BIT]));

   // sequencer: boot unprotect, then software operations
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_q <= SEQ_WR_ENABLE;
         wait_q <= 1'b0;
         poll_q <= 24'h000000;
         boot_done_q <= 1'b0;
         latch_ok_q <= 1'b0;
         flash_stat_q <= FLASH_STAT_RST;
         rdata_q <= RDATA_RST;
      end
      else if (go)
      begin
         wait_q <= 1'b1;
      end
      else if (done_q)
      begin
         wait_q <= 1'b0;
         case (seq_q)
            SEQ_WR_ENABLE:
            begin
               seq_q <= SEQ_POLL_LATCH;
               poll_q <= 24'h000000;
            end
            SEQ_POLL_LATCH:
            begin
               flash_stat_q <= stat_in;
               if (stat_in[WRITE_LATCH_FLAG_BIT])
               begin
                  latch_ok_q <= 1'b1;
                  seq_q <= SEQ_COMMAND;
               end
               else if (poll_fail)
               begin
                  boot_done_q <= 1'b1;
                  seq_q <= SEQ_IDLE;
               end
               else
               begin
                  poll_q <= poll_q + 24'h000001;
               end
            end
            SEQ_COMMAND:
            begin
               latch_ok_q <= 1'b0;
               poll_q <= 24'h000000;
               if (!boot_done_q || (op_q != OP_READ))
               begin
                  seq_q <= SEQ_POLL_BUSY;
               end
               else
               begin
                  rdata_q <= rx_word_q >> {2'(2'd3 - len_q), 3'b000};
                  seq_q <= SEQ_IDLE;
               end
            end
            SEQ_POLL_BUSY:
            begin
               flash_stat_q <= stat_in;
               if (!stat_in[FLASH_BUSY_FLAG_BIT] || poll_fail)
               begin
                  boot_done_q <= 1'b1;
                  seq_q <= SEQ_IDLE;
               end
               else
               begin
                  poll_q <= poll_q + 24'h000001;
               end
            end
            default: seq_q <= SEQ_IDLE;
         endcase
      end
      else if (start_req)
      begin
         // reads skip write enable; program and erase ask for it every time
         // op_q is loaded on this same edge, so decode the written operation
         seq_q <= (bfs_op_t'(pwdata[CTRL_OP_LSB +: 2]) == OP_READ) ? SEQ_COMMAND
            : SEQ_WR_ENABLE;
      end
   end

   // sticky error, a new timeout beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         err_q <= 1'b0;
      end
      else if (poll_fail)
      begin
         err_q <= 1'b1;
      end
      else if (clr_err)
      begin
         err_q <= 1'b0;
      end
   end

   // data line from the flash, two-flop synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         miso_m_q <= 1'b0;
         miso_s_q <= 1'b0;
      end
      else
      begin
         miso_m_q <= flash_miso;
         miso_s_q <= miso_m_q;
      end
   end

   // fixed schedule: slow until boot ends, then fast
   assign half = boot_done_q ? FAST_HALF : SLOW_HALF;

   // bit engine: mode 0, msb first, sample at end of the high half
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eng_q <= ENG_IDLE;
         cnt_q <= 6'd0;
         tx_q <= 72'h0;
         bits_q <= 7'd0;
         bit_idx_q <= 3'd0;
         rx_byte_q <= 8'h00;
         rx_word_q <= 32'h00000000;
         done_q <= 1'b0;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         cs0_n_q <= 1'b1;
         cs1_n_q <= 1'b1;
      end
      else
      begin
         done_q <= 1'b0;
         cs1_n_q <= 1'b1;
         case (eng_q)
            ENG_IDLE:
            begin
               if (go)
               begin
                  eng_q <= ENG_LOW;
                  cnt_q <= 6'd0;
                  tx_q <= tx_next;
                  bits_q <= bits_next;
                  bit_idx_q <= 3'd0;
                  mosi_q <= tx_next[71];
                  cs0_n_q <= 1'b0;
               end
            end
            ENG_LOW:
            begin
               if (cnt_q == half - 6'd1)
               begin
                  cnt_q <= 6'd0;
                  sclk_q <= 1'b1;
                  eng_q <= ENG_HIGH;
               end
               else
               begin
                  cnt_q <= cnt_q + 6'd1;
               end
            end
            ENG_HIGH:
            begin
               if (cnt_q == half - 6'd1)
               begin
                  cnt_q <= 6'd0;
                  sclk_q <= 1'b0;
                  tx_q <= tx_q << 1;
                  mosi_q <= tx_q[70];
                  rx_byte_q <= {rx_byte_q[6:0], miso_s_q};
                  bit_idx_q <= bit_idx_q + 3'd1;
                  bits_q <= bits_q - 7'd1;
                  if (bit_idx_q == 3'd7)
                  begin
                     rx_word_q <= {rx_byte_q[6:0], miso_s_q, rx_word_q[31:8]};
                  end
                  if (bits_q == 7'd1)
                  begin
                     cs0_n_q <= 1'b1;
                     mosi_q <= 1'b0;
                     eng_q <= ENG_GAP;
                  end
                  else
                  begin
                     eng_q <= ENG_LOW;
                  end
               end
               else
               begin
                  cnt_q <= cnt_q + 6'd1;
               end
            end
            ENG_GAP:
            begin
               if (cnt_q == CS_HIGH_CYC - 6'd1)
               begin
                  cnt_q <= 6'd0;
                  done_q <= 1'b1;
                  eng_q <= ENG_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q + 6'd1;
               end
            end
            default: eng_q <= ENG_IDLE;
         endcase
      end
   end

   // checks on the flash link and sequencing
   AST_AUX_SELECT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      aux_flash_select_n)
      else $error("second select line driven low");
   AST_MODE0_IDLE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      boot_flash_select_n |-> !flash_sclk)
      else $error("serial clock high while deselected");
   AST_MOSI_STABLE_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      (flash_sclk && $past(flash_sclk)) |-> $stable(flash_mosi))
      else $error("data out changed during clock high");
   AST_SLOW_AT_BOOT: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(flash_sclk) && !boot_done_q) |-> flash_sclk[*8])
      else $error("boot clock faster than slow rate");
   AST_FAST_AFTER_BOOT: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(flash_sclk) && boot_done_q) |=> flash_sclk ##1 !flash_sclk)
      else $error("fast clock high time wrong");
   AST_STATUS_WRITE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      (go && tx_next[71:64] == STATUS_WRITE_CMD) |->
         (tx_next[63:56] == STATUS_CLEAR) && (bits_next == 7'd16) && latch_ok_q)
      else $error("status write not a single zero byte after latch");
   AST_LATCH_BEFORE_PROG: assert property (@(posedge pclk) disable iff (!presetn)
      (go && (tx_next[71:64] == PAGE_PROGRAM_CMD || tx_next[71:64] == SECTOR_ERASE_CMD
         || tx_next[71:64] == CHIP_ERASE_CMD)) |-> latch_ok_q)
      else $error("program or erase without latch seen");
   AST_STATUS_READ_ONE_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
      (go && tx_next[71:64] == STATUS_READ_CMD) |-> bits_next == 7'd16)
      else $error("status read not one byte");
   AST_BOOT_BEFORE_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      !boot_done_q |-> (seq_q != SEQ_IDLE))
      else $error("idle before boot unprotect finished");
   AST_BUSY_CLEAR_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
      (done_q && seq_q == SEQ_POLL_BUSY && !stat_in[FLASH_BUSY_FLAG_BIT])
         |=> (seq_q == SEQ_IDLE) && boot_done_q)
      else $error("busy clear did not end sequence");
   AST_TIMEOUT_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
      poll_fail |=> err_q && (seq_q == SEQ_IDLE))
      else $error("poll timeout not reported");
endmodule
`default_nettype wire

// ===== test/bfs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfs_flash_model
(
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   input wire logic sel_n,
   input wire logic never_latch,
   input wire logic [1:0] lat_wait
);
   logic [7:0] stat = 8'h9c; // protection and lock on at power up
   logic [7:0] sh, op, obuf;
   logic [2:0] bc;
   logic [23:0] adr;
   logic [7:0] mem [int];
   logic [7:0] log [$];
   int nb, busy_n, lat_n;
   int n_bad = 0;
   // unwritten cells read back a fixed pattern
   function automatic logic [7:0] rd(input logic [23:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : (a[7:0] ^ 8'h5a);
   endfunction
   // one whole byte taken from the link
   task automatic take_byte();
      if (nb == 0)
      begin
         op = sh;
         log.push_back(sh);
      end
      else if (nb < 4 && op inside {8'h0b, 8'h02, 8'h20})
         adr = {adr[15:0], sh};
      else if (op == 8'h01)
      begin
         if (nb > 1)
            n_bad++;
         else if (stat[1])
            stat[7:2] = sh[7:2];
      end
      else if (op == 8'h02 && stat[1])
      begin
         mem[int'(adr)] = sh;
         adr++;
      end
      else if (op == 8'h0b && nb > 4)
         adr++;
      nb++;
      obuf = (op == 8'h05) ? stat : (op == 8'h0b && nb >= 5) ? rd(adr) : 8'h00;
   endtask
   // frame start, serial clock must idle low
   always @(negedge sel_n)
   begin
      nb = 0;
      bc = 3'd0;
      if (sclk !== 1'b0)
         n_bad++;
   end
   // sample on rising serial clock, msb first
   always @(posedge sclk)
   begin
      if (!sel_n)
      begin
         sh = {sh[6:0], mosi};
         bc = bc + 3'd1;
         if (bc == 3'd0)
            take_byte();
      end
   end
   // drive after the falling clock; released line inverts
   always @(negedge sclk or posedge sel_n)
   begin
      if (sel_n)
         miso <= ~miso;
      else
         miso <= obuf[3'd7 - bc];
   end
   // frame end: latch and busy bookkeeping
   always @(posedge sel_n)
   begin
      if (bc != 3'd0)
         n_bad++;
      if (op == 8'h06 && !never_latch)
      begin
         lat_n = int'(lat_wait);
         stat[1] = (lat_wait == 2'd0);
      end
      else if (op == 8'h05)
      begin
         lat_n--;
         busy_n--;
         if (lat_n == 0)
            stat[1] = 1'b1;
         if (busy_n == 0)
            stat[0] = 1'b0;
      end
      else if (op inside {8'h01, 8'h02, 8'h20, 8'hc7} && stat[1])
      begin
         stat[1:0] = 2'b01;
         busy_n = 2;
      end
   end
   initial
      miso = 1'b0;
endmodule
`default_nettype wire

// ===== test/tb_boot_flash_spi_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_boot_flash_spi_sequencer;
   import bfs_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic never_latch = 1'b0;
   logic [1:0] lat_wait = 2'd2;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, serr, sclk, mosi, miso, sel0_n, sel1_n;
   int n_mismatch = 0;
   int n_checks = 0;
   always #5 pclk = ~pclk;
   bfs_sequencer #(.POLL_LIMIT(24'h000008)) u_bfs_sequencer (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_sclk(sclk),
      .flash_mosi(mosi), .flash_miso(miso), .boot_flash_select_n(sel0_n),
      .aux_flash_select_n(sel1_n));
   bfs_flash_model u_bfs_flash_model (.sclk(sclk), .mosi(mosi), .miso(miso), .sel_n(sel0_n),
      .never_latch(never_latch), .lat_wait(lat_wait));
   task automatic conclude();
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && t++ < 100);
      if (pready !== 1'b1)
         n_mismatch++;
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // poll until booted and idle
   task automatic wait_idle();
      int t;
      t = 0;
      do
         apb(1'b0, REG_STATUS, 32'h0);
      while ((rdat[STAT_SEQ_BUSY_BIT] !== 1'b0 || rdat[STAT_BOOT_DONE_BIT] !== 1'b1)
         && t++ < 20000);
      if (rdat[STAT_SEQ_BUSY_BIT] !== 1'b0 || rdat[STAT_BOOT_DONE_BIT] !== 1'b1)
         n_mismatch++;
   endtask
   task automatic go(input logic [1:0] o, input logic [1:0] l);
      apb(1'b1, REG_CTRL, (32'h1 << CTRL_START_BIT) | {28'h0, l, o});
   endtask
   // opcode order with repeated polls folded
   task automatic chk_log(input logic [31:0] exp);
      logic [31:0] v;
      v = 32'h0;
      foreach (u_bfs_flash_model.log[i])
         if (i == 0 || u_bfs_flash_model.log[i] != 8'h05 || u_bfs_flash_model.log[i-1] != 8'h05)
            v = {v[23:0], u_bfs_flash_model.log[i]};
      chk(v, exp);
      u_bfs_flash_model.log.delete();
   endtask
   // serial clock high time in pclk cycles
   task automatic half(input logic [5:0] exp);
      logic [5:0] n;
      n = 6'd0;
      @(posedge sclk);
      while (sclk === 1'b1)
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk({26'h0, n}, {26'h0, exp});
      // realign to a clock edge before the next bus call
      @(posedge pclk);
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      half(SLOW_HALF);
      wait_idle();
      chk_log(32'h06050105);
      chk({24'h0, u_bfs_flash_model.stat}, 32'h0);
      chk(rdat & 32'h0000ff07, 32'h00000002);
      lat_wait <= 2'd0;
      apb(1'b1, REG_ADDR, 32'h000123);
      apb(1'b1, REG_WDATA, 32'h000000a7);
      go(OP_PROGRAM, 2'd0);
      wait_idle();
      chk_log(32'h06050205);
      apb(1'b1, REG_ADDR, 32'h000200);
      apb(1'b1, REG_WDATA, 32'h44332211);
      go(OP_PROGRAM, 2'd3);
      wait_idle();
      chk_log(32'h06050205);
      go(OP_READ, 2'd3);
      half(FAST_HALF);
      wait_idle();
      chk_log(32'h0000000b);
      apb(1'b0, REG_RDATA, 32'h0);
      chk(rdat, 32'h44332211);
      apb(1'b1, REG_ADDR, 32'h000123);
      go(OP_READ, 2'd0);
      wait_idle();
      apb(1'b0, REG_RDATA, 32'h0);
      chk(rdat, 32'h000000a7);
      u_bfs_flash_model.log.delete();
      go(OP_SECTOR_ERASE, 2'd0);
      wait_idle();
      chk_log(32'h06052005);
      go(OP_CHIP_ERASE, 2'd0);
      wait_idle();
      chk_log(32'h0605c705);
      never_latch <= 1'b1;
      go(OP_SECTOR_ERASE, 2'd0);
      wait_idle();
      chk({31'h0, rdat[STAT_ERR_BIT]}, 32'h1);
      never_latch <= 1'b0;
      apb(1'b1, REG_CTRL, 32'h1 << CTRL_CLRERR_BIT);
      apb(1'b0, REG_STATUS, 32'h0);
      chk({31'h0, rdat[STAT_ERR_BIT]}, 32'h0);
      apb(1'b0, 12'h0f0, 32'h0);
      chk({31'h0, serr}, 32'h1);
      chk({31'h0, sel1_n}, 32'h1);
      chk(32'(u_bfs_flash_model.n_bad), 32'h0);
      conclude();
   end
   // watchdog against a hang
   initial
   begin
      repeat (90000) @(posedge pclk);
      n_mismatch++;
      conclude();
   end
endmodule
`default_nettype wire
